/* File: rtl/poc_top.sv */
/*
 Ten programmable output cells with APB configuration, preload and a
 test-only sum/enable pattern. Assumes the sum-of-products array sits
 outside on pclk; pins and the cell clock pin arrive asynchronously.
*/
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none

// Operation
// R01: Ten independent cells, twenty-two logic inputs passed to the array.
// R02: Three architecture bits per cell select one of eight setups.
// R03: All bits zero means registered, active low, product-term enable.
// R04: Bypass bit zero registers the sum, one passes it around.
// R05: Combinatorial cell pin is input and output; disabled it is input.
// R06: Registered cell feeds its flip-flop back to the array.
// R07: All cell flip-flops clock from the one dedicated clock input.
// R08: Flip-flops start with true output low, complement high.
// R09: Enable source chosen per cell, in either storage mode.
// R10: Source zero uses product term, one uses the low external enable.
// R11: Polarity bit zero gives active low, one active high.
// R12: Preload forces the cell flip-flops to known values.
// R13: Separate test pattern drives cells without using application logic.
// R14: Board ties every unused input to ground.
// R15: Preload may set any pattern on the registered outputs.
// R16: Pin feedback only in combinatorial mode.
// R17: Inactive enable floats the pin; active enable drives adjusted value.
module poc_top #(
	parameter int NCELL = poc_pkg::NCELL,
	parameter int NDED = poc_pkg::NDED
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [poc_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NCELL-1:0] sum_term,
	input wire logic [NCELL-1:0] oe_term,
	input wire logic [NDED-1:0] ded_in,
	input wire logic ext_oe_n,
	input wire logic cell_clk,
	input wire logic [NCELL-1:0] pin_in,
	output logic [NCELL-1:0] pin_out,
	output logic [NCELL-1:0] pin_oe_n,
	output logic [NCELL+NDED-1:0] array_in
);
	// ----------------------------------------------------------------
	// Decoding helpers
	// ----------------------------------------------------------------
	function automatic poc_pkg::poc_cfg_t cfg_of(input logic [31:0] arch,
		input int idx);
		cfg_of = poc_pkg::poc_cfg_t'(arch[idx*poc_pkg::CFG_W +: poc_pkg::CFG_W]);
	endfunction

	function automatic logic hit(input logic [poc_pkg::ADDR_W-1:0] a,
		input logic [7:0] off);
		hit = (a == off);
	endfunction

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	logic [NCELL-1:0] pin_s1_ff, pin_s2_ff, nxt_pin_s1, nxt_pin_s2;
	logic [NDED-1:0] ded_s1_ff, ded_s2_ff, nxt_ded_s1, nxt_ded_s2;
	logic oen_s1_ff, oen_s2_ff, nxt_oen_s1, nxt_oen_s2;
	logic ck_s1_ff, ck_s2_ff, ck_s3_ff, nxt_ck_s1, nxt_ck_s2, nxt_ck_s3;
	logic cell_edge;

	always_comb begin
		nxt_pin_s1 = pin_in;
		nxt_pin_s2 = pin_s1_ff;
		nxt_ded_s1 = ded_in;
		nxt_ded_s2 = ded_s1_ff;
		nxt_oen_s1 = ext_oe_n;
		nxt_oen_s2 = oen_s1_ff;
		nxt_ck_s1 = cell_clk;
		nxt_ck_s2 = ck_s1_ff;
		nxt_ck_s3 = ck_s2_ff;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1_ff <= '0;
			pin_s2_ff <= '0;
			ded_s1_ff <= '0;
			ded_s2_ff <= '0;
			oen_s1_ff <= poc_pkg::OE_N_RST;
			oen_s2_ff <= poc_pkg::OE_N_RST;
			ck_s1_ff <= poc_pkg::SYNC_RST;
			ck_s2_ff <= poc_pkg::SYNC_RST;
			ck_s3_ff <= poc_pkg::SYNC_RST;
		end else begin
			pin_s1_ff <= nxt_pin_s1;
			pin_s2_ff <= nxt_pin_s2;
			ded_s1_ff <= nxt_ded_s1;
			ded_s2_ff <= nxt_ded_s2;
			oen_s1_ff <= nxt_oen_s1;
			oen_s2_ff <= nxt_oen_s2;
			ck_s1_ff <= nxt_ck_s1;
			ck_s2_ff <= nxt_ck_s2;
			ck_s3_ff <= nxt_ck_s3;
		end
	end

	// R07: one clock pin
	// Cell clock pin is sampled, so it must stay well below pclk/4
	assign cell_edge = ck_s2_ff & ~ck_s3_ff;

	// ----------------------------------------------------------------
	// APB slave and registers
	// ----------------------------------------------------------------
	logic [31:0] arch_ff, nxt_arch;
	logic test_en_ff, nxt_test_en;
	logic [NCELL-1:0] tsum_ff, nxt_tsum, toe_ff, nxt_toe;
	logic [31:0] prdata_ff, nxt_prdata;
	logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
	logic setup, wr_acc, preload_wr, mapped;
	logic [NCELL-1:0] q_ff, oe_sel;

	assign setup = psel & ~penable;
	assign wr_acc = psel & penable & pready_ff & pwrite;
	// R12: preload strobe
	assign preload_wr = wr_acc & hit(paddr, poc_pkg::ADDR_PRELOAD);
	assign mapped = hit(paddr, poc_pkg::ADDR_ARCH) |
		hit(paddr, poc_pkg::ADDR_CTRL) | hit(paddr, poc_pkg::ADDR_TSUM) |
		hit(paddr, poc_pkg::ADDR_TOE) | hit(paddr, poc_pkg::ADDR_PRELOAD) |
		hit(paddr, poc_pkg::ADDR_STATUS);

	always_comb begin
		nxt_arch = arch_ff;
		nxt_test_en = test_en_ff;
		nxt_tsum = tsum_ff;
		nxt_toe = toe_ff;
		nxt_pready = setup;
		nxt_pslverr = setup & ~mapped;
		nxt_prdata = '0;
		// R02: three bits per cell
		if (wr_acc && hit(paddr, poc_pkg::ADDR_ARCH))
			nxt_arch = {2'h0, pwdata[NCELL*poc_pkg::CFG_W-1:0]};
		if (wr_acc && hit(paddr, poc_pkg::ADDR_CTRL))
			nxt_test_en = pwdata[poc_pkg::CTRL_TEST_POS];
		if (wr_acc && hit(paddr, poc_pkg::ADDR_TSUM))
			nxt_tsum = pwdata[NCELL-1:0];
		if (wr_acc && hit(paddr, poc_pkg::ADDR_TOE))
			nxt_toe = pwdata[NCELL-1:0];
		if (setup && !pwrite) begin
			if (hit(paddr, poc_pkg::ADDR_ARCH))
				nxt_prdata = arch_ff;
			if (hit(paddr, poc_pkg::ADDR_CTRL))
				nxt_prdata[poc_pkg::CTRL_TEST_POS] = test_en_ff;
			if (hit(paddr, poc_pkg::ADDR_TSUM))
				nxt_prdata[NCELL-1:0] = tsum_ff;
			if (hit(paddr, poc_pkg::ADDR_TOE))
				nxt_prdata[NCELL-1:0] = toe_ff;
			if (hit(paddr, poc_pkg::ADDR_PRELOAD))
				nxt_prdata[NCELL-1:0] = q_ff;
			if (hit(paddr, poc_pkg::ADDR_STATUS)) begin
				nxt_prdata[poc_pkg::STAT_Q_POS +: NCELL] = q_ff;
				nxt_prdata[poc_pkg::STAT_OE_POS +: NCELL] = oe_sel;
				nxt_prdata[poc_pkg::STAT_PIN_POS +: NCELL] = pin_s2_ff;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// R03: unprogrammed default
			arch_ff <= poc_pkg::ARCH_RST;
			test_en_ff <= 1'b0;
			tsum_ff <= '0;
			toe_ff <= '0;
			prdata_ff <= poc_pkg::REG_RST;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
		end else begin
			arch_ff <= nxt_arch;
			test_en_ff <= nxt_test_en;
			tsum_ff <= nxt_tsum;
			toe_ff <= nxt_toe;
			prdata_ff <= nxt_prdata;
			pready_ff <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;

	// ----------------------------------------------------------------
	// Output cells
	// ----------------------------------------------------------------
	logic [NCELL-1:0] sum_sel, nxt_q, val, nxt_pin_out, nxt_pin_oe_n, fb;
	logic [NCELL-1:0] pin_out_ff, pin_oe_n_ff;
	logic [NCELL+NDED-1:0] array_in_ff, nxt_array_in;

	// R13: test pattern replaces the array sums and enables
	assign sum_sel = test_en_ff ? tsum_ff : sum_term;

	genvar gi;
	generate
		for (gi = 0; gi < NCELL; gi++) begin : g_cell
			poc_pkg::poc_cfg_t c;
			assign c = cfg_of(arch_ff, gi);
			// R09: per-cell source in both modes
			// R10: product term or external low enable
			assign oe_sel[gi] = c.enable_source_bit ? ~oen_s2_ff :
				(test_en_ff ? toe_ff[gi] : oe_term[gi]);
			// R04: bypass skips the flip-flop
			assign val[gi] = c.register_bypass_bit ? sum_sel[gi] : q_ff[gi];
			// R06: registered feedback
			// R05: combinatorial pin feeds the array
			// R16: pin feedback only when bypassed
			assign fb[gi] = c.register_bypass_bit ? pin_s2_ff[gi] : q_ff[gi];
			// R11: polarity
			assign nxt_pin_out[gi] = c.polarity_select_bit ? val[gi] : ~val[gi];
		end
	endgenerate

	always_comb begin
		// R15: any pattern by preload, which wins over a clock edge
		if (preload_wr)
			nxt_q = pwdata[NCELL-1:0];
		else if (cell_edge)
			nxt_q = sum_sel;
		else
			nxt_q = q_ff;
		// R17: disabled cell floats
		nxt_pin_oe_n = ~oe_sel;
		// R01: twenty-two inputs to the array
		nxt_array_in = {fb, ded_s2_ff};
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// R08: Q low at power-up
			q_ff <= {NCELL{poc_pkg::Q_RST}};
			pin_out_ff <= '0;
			pin_oe_n_ff <= {NCELL{poc_pkg::OE_N_RST}};
			array_in_ff <= '0;
		end else begin
			q_ff <= nxt_q;
			pin_out_ff <= nxt_pin_out;
			pin_oe_n_ff <= nxt_pin_oe_n;
			array_in_ff <= nxt_array_in;
		end
	end

	assign pin_out = pin_out_ff;
	assign pin_oe_n = pin_oe_n_ff;
	assign array_in = array_in_ff;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	poc_pkg::poc_cfg_t c0;
	assign c0 = cfg_of(arch_ff, 0);

	sequence s_preload;
		psel && penable && pready_ff && pwrite &&
			paddr == poc_pkg::ADDR_PRELOAD;
	endsequence

	sequence s_clock_rise;
		!ck_s2_ff ##1 ck_s2_ff;
	endsequence

	preload_load_a: assert property (s_preload |=> // R12
		q_ff == $past(pwdata[NCELL-1:0]))
		else $error("preload value not loaded");
	cell_clock_a: assert property (cell_edge && !preload_wr |=> // R07
		q_ff == $past(sum_sel))
		else $error("cell register missed clock edge");
	cell_hold_a: assert property (!cell_edge && !preload_wr |=> // R07
		$stable(q_ff))
		else $error("cell register changed without clock");
	edge_detect_a: assert property (s_clock_rise ##0 !preload_wr |=> // R07
		q_ff == $past(sum_sel))
		else $error("cell clock edge not detected");
	bypass_high_a: assert property (c0 == 3'b011 |=> // R04
		pin_out_ff[0] == $past(sum_sel[0]))
		else $error("combinatorial active high output wrong");
	// Skip the releasing edge, the pins still show their reset values
	reg_low_a: assert property (presetn && c0 == 3'b000 |=> // R03
		pin_out_ff[0] == !$past(q_ff[0]) && pin_oe_n_ff[0] == !$past(oe_sel[0]))
		else $error("default cell output wrong");
	ext_enable_a: assert property (c0.enable_source_bit |=> // R10
		pin_oe_n_ff[0] == $past(oen_s2_ff))
		else $error("external enable not followed");
	term_enable_a: assert property (!c0.enable_source_bit && !test_en_ff |=> // R17
		pin_oe_n_ff[0] == !$past(oe_term[0]))
		else $error("product term enable not followed");
	reg_feedback_a: assert property (!c0.register_bypass_bit |=> // R06
		array_in_ff[NDED] == $past(q_ff[0]))
		else $error("registered feedback wrong");
	pin_feedback_a: assert property (c0.register_bypass_bit |=> // R05
		array_in_ff[NDED] == $past(pin_s2_ff[0]))
		else $error("pin feedback wrong");
	test_pattern_a: assert property (test_en_ff && c0 == 3'b000 |=> // R13
		pin_oe_n_ff[0] == !$past(toe_ff[0]))
		else $error("test pattern not selected");
endmodule

`default_nettype wire

/* File: rtl/poc_pkg.sv */
/*
 Constants and types shared by the programmable output cell block.
 Assumes an APB master with 32-bit data and byte addresses on paddr.
*/
package poc_pkg;
	localparam int NCELL = 10;
	localparam int NDED = 12;
	localparam int CFG_W = 3;
	localparam int ADDR_W = 8;
	localparam logic [7:0] ADDR_ARCH = 8'h00;
	localparam logic [7:0] ADDR_CTRL = 8'h04;
	localparam logic [7:0] ADDR_TSUM = 8'h08;
	localparam logic [7:0] ADDR_TOE = 8'h0C;
	localparam logic [7:0] ADDR_PRELOAD = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;
	localparam int CTRL_TEST_POS = 0;
	localparam int STAT_Q_POS = 0;
	localparam int STAT_OE_POS = 10;
	localparam int STAT_PIN_POS = 20;
	localparam logic [31:0] ARCH_RST = 32'h0000_0000;
	localparam logic [31:0] REG_RST = 32'h0000_0000;
	localparam logic Q_RST = 1'b0;
	localparam logic SYNC_RST = 1'b0;
	localparam logic OE_N_RST = 1'b1;

	typedef struct packed {
		logic enable_source_bit;
		logic register_bypass_bit;
		logic polarity_select_bit;
	} poc_cfg_t;
endpackage

/* File: verification/poc_top_tb_top.sv */
/*
 Self-checking bench for the programmable output cell block.
 Assumes an APB slave and the sync latencies of the design.
*/
`timescale 1ns/1ps
`default_nettype none
module poc_top_tb_top;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ext_oe_n = 1'b1;
	logic cell_clk = 1'b0, pready, pslverr, last_err;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, last_rd;
	logic [9:0] sum_term = '0, oe_term = '0, pin_in = '0, pin_out;
	logic [9:0] pin_oe_n, q, v, s, e;
	logic [11:0] ded_in = '0;
	logic [21:0] array_in;
	int n_errors = 0;
	int n_compared = 0;

	poc_top poc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sum_term(sum_term), .oe_term(oe_term),
		.ded_in(ded_in), .ext_oe_n(ext_oe_n), .cell_clk(cell_clk),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.array_in(array_in));

	always #50 pclk = ~pclk;

	// ----------------------------------------
	// Bus and check tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// No assumed latency; only the watchdog ends a stuck wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		last_rd = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(last_rd, exp);
	endtask

	// Cell clock stays at least two pclk in each level
	task automatic pulse;
		@(posedge pclk);
		cell_clk <= 1'b1;
		repeat (3) @(posedge pclk);
		cell_clk <= 1'b0;
		repeat (6) @(posedge pclk);
	endtask

	function automatic logic [31:0] rep(input logic [2:0] c);
		logic [31:0] r;
		r = '0;
		for (int i = 0; i < 10; i++) r[3*i+:3] = c;
		return r;
	endfunction

	task automatic test_done;
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Watchdog, generous against a few hundred cycles of tests
	// ----------------------------------------
	initial begin
		repeat (20000) @(posedge pclk);
		n_errors++;
		test_done();
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge pclk);
		chk(32'(pin_oe_n), 32'h3FF);
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		chk(32'(pin_out), 32'h3FF);
		chk(32'(array_in), 32'h0);
		rd(poc_pkg::ADDR_ARCH, 32'h0);
		rd(poc_pkg::ADDR_STATUS, 32'h0);
		$display("test reset done");
		apb(1'b1, 8'h3C, 32'hFFFF_FFFF);
		chk(32'(last_err), 32'h1);
		rd(8'h3C, 32'h0);
		apb(1'b1, poc_pkg::ADDR_ARCH, rep(3'h5));
		rd(poc_pkg::ADDR_ARCH, rep(3'h5));
		$display("test bus done");
		q = '0;
		// Every cell setup, registered ones checked before and after the clock
		for (int c = 0; c < 8; c++) begin
			apb(1'b1, poc_pkg::ADDR_ARCH, rep(3'(c)));
			s = 10'h2A5 ^ (10'(c) * 10'h49);
			e = c[2] ? {10{~c[1]}} : ~s ^ 10'h0F0;
			@(posedge pclk);
			sum_term <= s;
			oe_term <= ~s ^ 10'h0F0;
			ext_oe_n <= c[1];
			pin_in <= ~s;
			ded_in <= 12'hA5C ^ 12'(c);
			repeat (6) @(posedge pclk);
			if (c[1] == 1'b0) begin
				chk(32'(pin_out), c[0] ? {22'h0, q} : {22'h0, ~q});
				pulse();
				q = s;
				rd(poc_pkg::ADDR_STATUS, {2'h0, ~s, e, q});
			end
			v = c[1] ? s : q;
			chk(32'(pin_out), c[0] ? {22'h0, v} : {22'h0, ~v});
			chk(32'(pin_oe_n), {22'h0, ~e});
			chk(32'(array_in[21:12]), c[1] ? {22'h0, ~s} : {22'h0, q});
			chk(32'(array_in[11:0]), 32'(12'hA5C ^ 12'(c)));
		end
		$display("test modes done");
		apb(1'b1, poc_pkg::ADDR_ARCH, 32'h0);
		oe_term <= 10'h3FF;
		// Preload follows back to back patterns
		for (int p = 0; p < 2; p++) begin
			v = p ? 10'h2AA : 10'h155;
			apb(1'b1, poc_pkg::ADDR_PRELOAD, 32'(v));
			rd(poc_pkg::ADDR_PRELOAD, 32'(v));
			repeat (3) @(posedge pclk);
			chk(32'(pin_out), {22'h0, ~v});
		end
		$display("test preload done");
		apb(1'b1, poc_pkg::ADDR_TSUM, 32'h0F0);
		apb(1'b1, poc_pkg::ADDR_TOE, 32'h3C3);
		apb(1'b1, poc_pkg::ADDR_CTRL, 32'h1);
		rd(poc_pkg::ADDR_CTRL, 32'h1);
		rd(poc_pkg::ADDR_TSUM, 32'h0F0);
		pulse();
		chk(32'(pin_out), {22'h0, ~10'h0F0});
		chk(32'(pin_oe_n), {22'h0, ~10'h3C3});
		$display("test pattern done");
		test_done();
	end
endmodule
`default_nettype wire
